// ===== include/acif_pkg.sv
// Constants, field layouts and carrier types of the converter interrupt flag block.
// Functional notes
// - A line whose continue-mode bit is 0 issues no further interrupt while its flag stays set.
// - A line whose continue-mode bit is 1 issues an interrupt on every new event even with its flag set.
// - An event in the same cycle as a flag-clear write leaves the flag set.
// - An event that arrives while the line's flag is already set sets that line's overrun flag.
// - Writing 1 to a line's bit of the flag-clear register clears its flag, and a second write clears it again.
// - Writing 1 to a line's bit of the overrun-clear register clears its overrun flag.
// - In late mode the flag may rise before the result is latched, by 3 or more cycles when the divider exceeds 2.
// - The flag can trigger an accelerator task, a CPU interrupt, a DMA channel, or be polled by the CPU.
package acif_pkg;

	// ==========================================================
	// Sizes
	localparam int ACIF_LINES  = 4;
	localparam int ACIF_DATA_W = 32;
	localparam int ACIF_ADDR_W = 8;
	localparam int ACIF_RES_W  = 12;
	localparam int ACIF_DIV_W  = 4;
	localparam int ACIF_LOST_W = 16;

	// ==========================================================
	// Register offsets
	localparam logic [ACIF_ADDR_W-1:0] ACIF_OFS_CTRL     = 8'h00;
	localparam logic [ACIF_ADDR_W-1:0] ACIF_OFS_LINE_CFG = 8'h04;
	localparam logic [ACIF_ADDR_W-1:0] ACIF_OFS_ROUTE    = 8'h08;
	localparam logic [ACIF_ADDR_W-1:0] ACIF_OFS_FLAG     = 8'h0c;
	localparam logic [ACIF_ADDR_W-1:0] ACIF_OFS_FLAG_CLR = 8'h10;
	localparam logic [ACIF_ADDR_W-1:0] ACIF_OFS_OVR      = 8'h14;
	localparam logic [ACIF_ADDR_W-1:0] ACIF_OFS_OVR_CLR  = 8'h18;
	localparam logic [ACIF_ADDR_W-1:0] ACIF_OFS_RESULT   = 8'h1c;
	localparam logic [ACIF_ADDR_W-1:0] ACIF_OFS_IRQ_STAT = 8'h20;
	localparam logic [ACIF_ADDR_W-1:0] ACIF_OFS_IRQ_MASK = 8'h24;
	localparam logic [ACIF_ADDR_W-1:0] ACIF_OFS_LOST_CNT = 8'h28;
	localparam logic [ACIF_ADDR_W-1:0] ACIF_OFS_FORCE    = 8'h2c;

	// ==========================================================
	// Field positions
	localparam int ACIF_CTRL_DIV_LSB  = 0;
	localparam int ACIF_CTRL_LATE_BIT = 4;
	localparam int ACIF_CFG_EN_LSB    = 0;
	localparam int ACIF_CFG_CONT_LSB  = 4;
	localparam int ACIF_ROUTE_DMA_LSB = 0;
	localparam int ACIF_ROUTE_ACC_LSB = 4;
	localparam int ACIF_ROUTE_CPU_LSB = 8;
	localparam int ACIF_STAT_FLG_LSB  = 0;
	localparam int ACIF_STAT_OVR_LSB  = 4;
	localparam int ACIF_STAT_W        = 2 * ACIF_LINES;

	// ==========================================================
	// Reset values
	localparam logic [ACIF_DIV_W-1:0]  ACIF_DIV_RST   = 4'h3;
	localparam logic                   ACIF_LATE_RST  = 1'b1;
	localparam logic [ACIF_LINES-1:0]  ACIF_EN_RST    = 4'hf;
	localparam logic [ACIF_LINES-1:0]  ACIF_CONT_RST  = 4'h0;
	localparam logic [ACIF_LINES-1:0]  ACIF_ROUTE_RST = 4'h0;
	localparam logic [ACIF_STAT_W-1:0] ACIF_MASK_RST  = 8'h00;

	// ==========================================================
	// Timing
	localparam logic [ACIF_DIV_W-1:0] ACIF_LAT_MIN = 4'h1;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic enable;
		logic cont;
	} acif_line_cfg_t;

	typedef struct packed {
		logic flag;
		logic ovr;
		logic irq_pulse;
		logic lost;
	} acif_line_stat_t;

	typedef enum logic {ACIF_IDLE, ACIF_WAIT} acif_lat_state_t;

endpackage

// ===== rtl/acif_line.sv
// Per-line interrupt flag and overrun flag.
module acif_line
	import acif_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst_b,
	input  wire logic      ce,
	input  wire logic      event_in,
	input  wire logic      flag_clr,
	input  wire logic      ovr_clr,
	input  wire acif_line_cfg_t cfg,
	output acif_line_stat_t     stat
);

	logic flag_reg;
	logic ovr_reg;
	logic ev;

	assign ev = ce & event_in & cfg.enable;

	// ==========================================================
	// Flag: a new event beats a clear in the same cycle.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_reg <= 1'b0;
		end else if (ce) begin
			flag_reg <= ev | (flag_reg & ~flag_clr);
		end
	end

	// ==========================================================
	// Overrun: an event finding the flag set was lost.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ovr_reg <= 1'b0;
		end else if (ce) begin
			ovr_reg <= (ev & flag_reg) | (ovr_reg & ~ovr_clr);
		end
	end

	assign stat.flag      = flag_reg;
	assign stat.ovr       = ovr_reg;
	assign stat.irq_pulse = ev & (cfg.cont | ~flag_reg);
	assign stat.lost      = ev & flag_reg;

endmodule

// ===== rtl/acif_latch.sv
// Delayed result latch that follows a conversion by the divider count.
module acif_latch
	import acif_pkg::*;
#(
	parameter int RES_W = ACIF_RES_W,
	parameter int DIV_W = ACIF_DIV_W
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             ce,
	input  wire logic             start,
	input  wire logic [RES_W-1:0] data_in,
	input  wire logic [DIV_W-1:0] div,
	output logic      [RES_W-1:0] result,
	output logic                  done
);

	acif_lat_state_t  state_reg;
	logic [DIV_W-1:0] cnt_reg;
	logic [RES_W-1:0] hold_reg;

	// ==========================================================
	// A new conversion during a wait restarts it; the older result is never shown.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ACIF_IDLE;
			cnt_reg   <= '0;
			hold_reg  <= '0;
			result    <= '0;
			done      <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (start) begin
				state_reg <= ACIF_WAIT;
				hold_reg  <= data_in;
				cnt_reg   <= (div < ACIF_LAT_MIN) ? ACIF_LAT_MIN : div;
			end else begin
				unique case (state_reg)
					ACIF_IDLE: begin
						cnt_reg <= cnt_reg;
					end
					ACIF_WAIT: begin
						if (cnt_reg == ACIF_LAT_MIN) begin
							result    <= hold_reg;
							done      <= 1'b1;
							state_reg <= ACIF_IDLE;
						end else begin
							cnt_reg <= cnt_reg - ACIF_LAT_MIN;
						end
					end
				endcase
			end
		end
	end

endmodule

// ===== rtl/acif_top.sv
// Converter interrupt flag, overrun and trigger logic with its APB register file.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
module acif_top
	import acif_pkg::*;
(
	input  wire logic                   MCLK,
	input  wire logic                   RST_B,
	input  wire logic                   CLK_EN,
	input  wire logic                   PSEL,
	input  wire logic                   PENABLE,
	input  wire logic                   PWRITE,
	input  wire logic [ACIF_ADDR_W-1:0] PADDR,
	input  wire logic [ACIF_DATA_W-1:0] PWDATA,
	output logic      [ACIF_DATA_W-1:0] PRDATA,
	output logic                        PREADY,
	output logic                        PSLVERR,
	input  wire logic                   CONV_DONE,
	input  wire logic [ACIF_RES_W-1:0]  CONV_DATA,
	output logic      [ACIF_RES_W-1:0]  CONVERSION_RESULT,
	output logic      [ACIF_LINES-1:0]  CONV_IRQ_FLAG,
	output logic      [ACIF_LINES-1:0]  TRIG_DMA,
	output logic      [ACIF_LINES-1:0]  TRIG_ACCEL,
	output logic      [ACIF_LINES-1:0]  TRIG_CPU,
	output logic                        IRQ
);

	// ==========================================================
	// Declarations
	logic [ACIF_DIV_W-1:0]  div_reg;
	logic                   late_reg;
	logic [ACIF_LINES-1:0]  en_reg;
	logic [ACIF_LINES-1:0]  cont_reg;
	logic [ACIF_LINES-1:0]  route_dma_reg;
	logic [ACIF_LINES-1:0]  route_acc_reg;
	logic [ACIF_LINES-1:0]  route_cpu_reg;
	logic [ACIF_STAT_W-1:0] irq_stat_reg;
	logic [ACIF_STAT_W-1:0] irq_mask_reg;
	logic [ACIF_LOST_W-1:0] lost_cnt_reg;
	logic [ACIF_LOST_W-1:0] lost_cnt_next;
	logic [ACIF_DATA_W-1:0] rdata_reg;
	logic                   slverr_reg;
	logic                   irq_reg;
	logic [ACIF_LINES-1:0]  trig_dma_reg;
	logic [ACIF_LINES-1:0]  trig_acc_reg;
	logic [ACIF_LINES-1:0]  trig_cpu_reg;

	logic                   setup;
	logic                   wr_en;
	logic                   addr_hit;
	logic [ACIF_DATA_W-1:0] rd_mux;
	logic                   latch_done;
	logic                   line_src;
	logic [ACIF_LINES-1:0]  force_evt;
	logic [ACIF_LINES-1:0]  flag_clr;
	logic [ACIF_LINES-1:0]  ovr_clr;
	logic [ACIF_LINES-1:0]  flag_vec;
	logic [ACIF_LINES-1:0]  ovr_vec;
	logic [ACIF_LINES-1:0]  pulse_vec;
	logic [ACIF_LINES-1:0]  lost_vec;
	logic [ACIF_STAT_W-1:0] stat_set;
	logic [ACIF_STAT_W-1:0] stat_clr;
	acif_line_stat_t        stat [ACIF_LINES];

	// ==========================================================
	// Bus decode
	// The slave never inserts wait states, but holds every transfer while the clock enable is low.
	assign PREADY = CLK_EN;
	assign setup  = PSEL & ~PENABLE;
	assign wr_en  = PSEL & PENABLE & PWRITE & CLK_EN & addr_hit;

	always_comb begin
		unique case (PADDR)
			ACIF_OFS_CTRL,
			ACIF_OFS_LINE_CFG,
			ACIF_OFS_ROUTE,
			ACIF_OFS_FLAG,
			ACIF_OFS_FLAG_CLR,
			ACIF_OFS_OVR,
			ACIF_OFS_OVR_CLR,
			ACIF_OFS_RESULT,
			ACIF_OFS_IRQ_STAT,
			ACIF_OFS_IRQ_MASK,
			ACIF_OFS_LOST_CNT,
			ACIF_OFS_FORCE: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end

	// Strobes for the write-one registers only last during the access cycle.
	assign force_evt = (wr_en && PADDR == ACIF_OFS_FORCE) ? PWDATA[ACIF_LINES-1:0] : '0;
	assign flag_clr  = (wr_en && PADDR == ACIF_OFS_FLAG_CLR) ? PWDATA[ACIF_LINES-1:0] : '0;
	assign ovr_clr   = (wr_en && PADDR == ACIF_OFS_OVR_CLR) ? PWDATA[ACIF_LINES-1:0] : '0;

	// ==========================================================
	// Read data
	always_comb begin
		rd_mux = '0;
		unique case (PADDR)
			ACIF_OFS_CTRL: begin
				rd_mux[ACIF_CTRL_DIV_LSB +: ACIF_DIV_W] = div_reg;
				rd_mux[ACIF_CTRL_LATE_BIT]              = late_reg;
			end
			ACIF_OFS_LINE_CFG: begin
				rd_mux[ACIF_CFG_EN_LSB +: ACIF_LINES]   = en_reg;
				rd_mux[ACIF_CFG_CONT_LSB +: ACIF_LINES] = cont_reg;
			end
			ACIF_OFS_ROUTE: begin
				rd_mux[ACIF_ROUTE_DMA_LSB +: ACIF_LINES] = route_dma_reg;
				rd_mux[ACIF_ROUTE_ACC_LSB +: ACIF_LINES] = route_acc_reg;
				rd_mux[ACIF_ROUTE_CPU_LSB +: ACIF_LINES] = route_cpu_reg;
			end
			ACIF_OFS_FLAG: begin
				rd_mux[ACIF_LINES-1:0] = flag_vec;
			end
			ACIF_OFS_OVR: begin
				rd_mux[ACIF_LINES-1:0] = ovr_vec;
			end
			ACIF_OFS_RESULT: begin
				rd_mux[ACIF_RES_W-1:0] = CONVERSION_RESULT;
			end
			ACIF_OFS_IRQ_STAT: begin
				rd_mux[ACIF_STAT_W-1:0] = irq_stat_reg;
			end
			ACIF_OFS_IRQ_MASK: begin
				rd_mux[ACIF_STAT_W-1:0] = irq_mask_reg;
			end
			ACIF_OFS_LOST_CNT: begin
				rd_mux[ACIF_LOST_W-1:0] = lost_cnt_reg;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	// Read data is captured in the setup cycle so that it leaves a flip-flop.
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata_reg  <= '0;
			slverr_reg <= 1'b0;
		end else if (CLK_EN && setup) begin
			rdata_reg  <= PWRITE ? '0 : rd_mux;
			slverr_reg <= ~addr_hit;
		end
	end

	assign PRDATA  = rdata_reg;
	assign PSLVERR = PSEL & PENABLE & slverr_reg;

	// ==========================================================
	// Control registers
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			div_reg  <= ACIF_DIV_RST;
			late_reg <= ACIF_LATE_RST;
		end else if (wr_en && PADDR == ACIF_OFS_CTRL) begin
			div_reg  <= PWDATA[ACIF_CTRL_DIV_LSB +: ACIF_DIV_W];
			late_reg <= PWDATA[ACIF_CTRL_LATE_BIT];
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			en_reg   <= ACIF_EN_RST;
			cont_reg <= ACIF_CONT_RST;
		end else if (wr_en && PADDR == ACIF_OFS_LINE_CFG) begin
			en_reg   <= PWDATA[ACIF_CFG_EN_LSB +: ACIF_LINES];
			cont_reg <= PWDATA[ACIF_CFG_CONT_LSB +: ACIF_LINES];
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			route_dma_reg <= ACIF_ROUTE_RST;
			route_acc_reg <= ACIF_ROUTE_RST;
			route_cpu_reg <= ACIF_ROUTE_RST;
		end else if (wr_en && PADDR == ACIF_OFS_ROUTE) begin
			route_dma_reg <= PWDATA[ACIF_ROUTE_DMA_LSB +: ACIF_LINES];
			route_acc_reg <= PWDATA[ACIF_ROUTE_ACC_LSB +: ACIF_LINES];
			route_cpu_reg <= PWDATA[ACIF_ROUTE_CPU_LSB +: ACIF_LINES];
		end
	end

	// ==========================================================
	// Result latch
	// In late mode lines fire on the conversion itself, ahead of the latch by the divider count.
	acif_latch #(
		.RES_W (ACIF_RES_W),
		.DIV_W (ACIF_DIV_W)
	) u_latch (
		.clk     (MCLK),
		.rst_b   (RST_B),
		.ce      (CLK_EN),
		.start   (CONV_DONE),
		.data_in (CONV_DATA),
		.div     (div_reg),
		.result  (CONVERSION_RESULT),
		.done    (latch_done)
	);

	assign line_src = late_reg ? CONV_DONE : latch_done;

	// ==========================================================
	// Interrupt lines
	generate
		for (genvar i = 0; i < ACIF_LINES; i++) begin : g_line
			acif_line_cfg_t cfg;

			assign cfg.enable = en_reg[i];
			assign cfg.cont   = cont_reg[i];

			acif_line u_line (
				.clk      (MCLK),
				.rst_b    (RST_B),
				.ce       (CLK_EN),
				.event_in (line_src | force_evt[i]),
				.flag_clr (flag_clr[i]),
				.ovr_clr  (ovr_clr[i]),
				.cfg      (cfg),
				.stat     (stat[i])
			);

			assign flag_vec[i]  = stat[i].flag;
			assign ovr_vec[i]   = stat[i].ovr;
			assign pulse_vec[i] = stat[i].irq_pulse;
			assign lost_vec[i]  = stat[i].lost;
		end
	endgenerate

	assign CONV_IRQ_FLAG = flag_vec;

	// ==========================================================
	// Trigger outputs
	// Any number of DMA channels may listen to one line; pairing them is left to the system.
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			trig_dma_reg <= '0;
			trig_acc_reg <= '0;
			trig_cpu_reg <= '0;
		end else if (CLK_EN) begin
			trig_dma_reg <= pulse_vec & route_dma_reg;
			trig_acc_reg <= pulse_vec & route_acc_reg;
			trig_cpu_reg <= pulse_vec & route_cpu_reg;
		end
	end

	assign TRIG_DMA   = trig_dma_reg;
	assign TRIG_ACCEL = trig_acc_reg;
	assign TRIG_CPU   = trig_cpu_reg;

	// ==========================================================
	// Interrupt status and mask
	assign stat_set = {lost_vec, pulse_vec};
	assign stat_clr = (wr_en && PADDR == ACIF_OFS_IRQ_STAT) ? PWDATA[ACIF_STAT_W-1:0] : '0;

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			irq_stat_reg <= '0;
		end else if (CLK_EN) begin
			irq_stat_reg <= stat_set | (irq_stat_reg & ~stat_clr);
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			irq_mask_reg <= ACIF_MASK_RST;
		end else if (wr_en && PADDR == ACIF_OFS_IRQ_MASK) begin
			irq_mask_reg <= PWDATA[ACIF_STAT_W-1:0];
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			irq_reg <= 1'b0;
		end else if (CLK_EN) begin
			irq_reg <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	assign IRQ = irq_reg;

	// ==========================================================
	// Lost event counter
	// The count saturates so that a long storm still reads as nonzero.
	always_comb begin
		lost_cnt_next = lost_cnt_reg;
		for (int k = 0; k < ACIF_LINES; k++) begin
			if (lost_vec[k] && lost_cnt_next != '1) begin
				lost_cnt_next = lost_cnt_next + 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			lost_cnt_reg <= '0;
		end else if (wr_en && PADDR == ACIF_OFS_LOST_CNT) begin
			lost_cnt_reg <= '0;
		end else if (CLK_EN) begin
			lost_cnt_reg <= lost_cnt_next;
		end
	end

endmodule

// ===== verif/acif_checker.sv
// Port checker of the converter interrupt flag block.
module acif_checker
	import acif_pkg::*;
(
	input wire logic                   MCLK,
	input wire logic                   RST_B,
	input wire logic                   CLK_EN,
	input wire logic                   PSEL,
	input wire logic                   PENABLE,
	input wire logic                   PWRITE,
	input wire logic [ACIF_ADDR_W-1:0] PADDR,
	input wire logic [ACIF_DATA_W-1:0] PWDATA,
	input wire logic                   PREADY,
	input wire logic                   PSLVERR,
	input wire logic                   CONV_DONE,
	input wire logic [ACIF_RES_W-1:0]  CONV_DATA,
	input wire logic [ACIF_RES_W-1:0]  CONVERSION_RESULT,
	input wire logic [ACIF_LINES-1:0]  CONV_IRQ_FLAG,
	input wire logic [ACIF_LINES-1:0]  TRIG_DMA,
	input wire logic [ACIF_LINES-1:0]  TRIG_CPU
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Shadow configuration, so that conditions can be stated at the ports.
	logic        wr;
	logic [7:0]  cfg_reg;
	logic [11:0] route_reg;
	logic [4:0]  ctrl_reg;
	logic [1:0]  clr_reg;
	assign wr = PSEL && PENABLE && PWRITE && PREADY;
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			cfg_reg   <= {ACIF_CONT_RST, ACIF_EN_RST};
			route_reg <= '0;
			ctrl_reg  <= {ACIF_LATE_RST, ACIF_DIV_RST};
			clr_reg   <= '0;
		end else begin
			clr_reg <= {clr_reg[0], wr && PADDR == ACIF_OFS_FLAG_CLR};
			if (wr && PADDR == ACIF_OFS_LINE_CFG) cfg_reg <= PWDATA[7:0];
			if (wr && PADDR == ACIF_OFS_ROUTE) route_reg <= PWDATA[11:0];
			if (wr && PADDR == ACIF_OFS_CTRL) ctrl_reg <= PWDATA[4:0];
		end
	end
	// ==========================================================
	// Properties
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	sequence s_cont_evt;
		CONV_DONE && CLK_EN && ctrl_reg[4] && cfg_reg[0] && cfg_reg[4] && route_reg[8];
	endsequence
	sequence s_quiet;
		$stable(CONVERSION_RESULT) [*3];
	endsequence
	property p_block;
		!cfg_reg[4] && $past(CONV_IRQ_FLAG[0], 2) && $past(CONV_IRQ_FLAG[0]) && clr_reg == 2'b00 |-> !TRIG_CPU[0];
	endproperty
	a_block: assert property (p_block) else $error("line 0 pulsed while its flag was held");
	property p_cont;
		s_cont_evt |-> ##[1:2] TRIG_CPU[0];
	endproperty
	a_cont: assert property (p_cont) else $error("continue mode event gave no pulse");
	property p_first;
		CONV_DONE && CLK_EN && ctrl_reg[4] && cfg_reg[0] && route_reg[0] && !CONV_IRQ_FLAG[0] |-> ##[1:2] TRIG_DMA[0];
	endproperty
	a_first: assert property (p_first) else $error("first event gave no transfer trigger");
	property p_set_wins;
		wr && PADDR == ACIF_OFS_FLAG_CLR && PWDATA[0] && CONV_DONE && CLK_EN && ctrl_reg[4] && cfg_reg[0]
			|=> CONV_IRQ_FLAG[0];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag lost on a colliding clear");
	property p_clear;
		wr && PADDR == ACIF_OFS_FLAG_CLR && PWDATA[0] && !CONV_DONE && ctrl_reg[4] |=> !CONV_IRQ_FLAG[0];
	endproperty
	a_clear: assert property (p_clear) else $error("flag clear write did not clear");
	property p_lead;
		$rose(CONV_IRQ_FLAG[0]) && ctrl_reg[4] && ctrl_reg[3:0] > 4'h2 |-> s_quiet;
	endproperty
	a_lead: assert property (p_lead) else $error("result moved within 3 cycles of the flag");
	property p_latch;
		CONV_DONE && CLK_EN && ctrl_reg[3:0] == 4'h3 |-> ##4 CONVERSION_RESULT == $past(CONV_DATA, 4);
	endproperty
	a_latch: assert property (p_latch) else $error("result not latched after the divider count");
	property p_err;
		PSEL && PENABLE && PADDR > ACIF_OFS_FORCE |-> PSLVERR;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access without slave error");
endmodule

// ===== verif/acif_dma_model.sv
// Far-side model: two transfer channels started by the line 0 trigger.
module acif_dma_model
	import acif_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic                  trig,
	input  wire logic [ACIF_RES_W-1:0] result,
	output logic      [ACIF_RES_W-1:0] stale_data,
	output logic      [ACIF_RES_W-1:0] fresh_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] pipe_reg;
	// An idle channel reads as early as it can, which is what exposes the old result.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pipe_reg   <= '0;
			stale_data <= '0;
			fresh_data <= '0;
		end else begin
			pipe_reg <= {pipe_reg[4:0], trig};
			if (pipe_reg[1]) stale_data <= result;
			if (pipe_reg[4]) fresh_data <= result;
		end
	end
endmodule

// ===== verif/acif_top_tb.sv
// Self-checking bench of the converter interrupt flag block.
module acif_top_tb
	import acif_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic                   mclk = 1'b0;
	logic                   rst_b, clk_en, psel, penable, pwrite, conv_done, pready, pslverr, irq, erv;
	logic [ACIF_ADDR_W-1:0] paddr;
	logic [ACIF_DATA_W-1:0] pwdata, prdata, rdv;
	logic [ACIF_RES_W-1:0]  conv_data, result, stale, fresh;
	logic [ACIF_LINES-1:0]  flag, trig_dma, trig_accel, trig_cpu;
	int                     fails = 0;
	int                     cmp_count = 0;
	int                     pulses = 0;
	int                     accs = 0;
	always #20 mclk = ~mclk;
	always @(posedge mclk) if (trig_cpu[0] === 1'b1) pulses <= pulses + 1;
	always @(posedge mclk) if (trig_accel[3] === 1'b1) accs <= accs + 1;
	acif_top dut_u (.MCLK(mclk), .RST_B(rst_b), .CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.CONV_DONE(conv_done), .CONV_DATA(conv_data), .CONVERSION_RESULT(result), .CONV_IRQ_FLAG(flag),
		.TRIG_DMA(trig_dma), .TRIG_ACCEL(trig_accel), .TRIG_CPU(trig_cpu), .IRQ(irq));
	acif_dma_model dma_u (.clk(mclk), .rst_b(rst_b), .trig(trig_dma[0]), .result(result),
		.stale_data(stale), .fresh_data(fresh));
	// ==========================================================
	// Bus and check helpers
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fails++;
		rdv = prdata;
		erv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wrt(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, e, rdv);
	endtask
	task automatic conv(input logic [11:0] d);
		@(posedge mclk);
		conv_done <= 1'b1;
		conv_data <= d;
		@(posedge mclk);
		conv_done <= 1'b0;
		repeat (10) @(posedge mclk);
	endtask
	task automatic clear_all();
		wrt(ACIF_OFS_FLAG_CLR, 32'hf);
		wrt(ACIF_OFS_OVR_CLR, 32'hf);
		wrt(ACIF_OFS_IRQ_STAT, 32'hff);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		rchk(ACIF_OFS_CTRL, {27'h0, ACIF_LATE_RST, ACIF_DIV_RST}, "ctrl");
		rchk(ACIF_OFS_LINE_CFG, 32'hf, "line cfg");
		rchk(ACIF_OFS_ROUTE, 32'h0, "route");
		rchk(8'h30, 32'h0, "unmapped data");
		chk("unmapped err", 32'h1, 32'(erv));
	endtask
	task automatic t_block();
		int p0;
		wrt(ACIF_OFS_ROUTE, 32'hfff);
		p0 = pulses;
		conv(12'h123);
		conv(12'h456);
		chk("held pulses", 32'h1, 32'(pulses - p0));
		rchk(ACIF_OFS_OVR, 32'hf, "overrun");
		wrt(ACIF_OFS_FLAG_CLR, 32'h1);
		apb(1'b0, ACIF_OFS_OVR, 32'h0);
		if (rdv[0]) wrt(ACIF_OFS_FLAG_CLR, 32'h1);
		@(negedge mclk);
		chk("flags after clear", 32'he, 32'(flag));
		wrt(ACIF_OFS_OVR_CLR, 32'h3);
		rchk(ACIF_OFS_OVR, 32'hc, "overrun clear");
		clear_all();
	endtask
	task automatic t_cont();
		int p0;
		int a0;
		wrt(ACIF_OFS_LINE_CFG, 32'hff);
		p0 = pulses;
		a0 = accs;
		conv(12'h321);
		conv(12'h654);
		chk("continue pulses", 32'h2, 32'(pulses - p0));
		chk("accel pulses", 32'h2, 32'(accs - a0));
		clear_all();
		wrt(ACIF_OFS_LINE_CFG, 32'hf);
	endtask
	task automatic t_collide();
		conv(12'h0aa);
		fork
			wrt(ACIF_OFS_FLAG_CLR, 32'h1);
			begin
				repeat (2) @(posedge mclk);
				conv_done <= 1'b1;
				@(posedge mclk);
				conv_done <= 1'b0;
			end
		join
		@(negedge mclk);
		chk("flag after collision", 32'h1, 32'(flag[0]));
		wrt(ACIF_OFS_FLAG_CLR, 32'h1);
		@(negedge mclk);
		chk("flag after second clear", 32'h0, 32'(flag[0]));
		clear_all();
	endtask
	task automatic t_dma();
		wrt(ACIF_OFS_CTRL, 32'h15);
		conv(12'h111);
		wrt(ACIF_OFS_FLAG_CLR, 32'hf);
		conv(12'h2a5);
		chk("early read", 32'h111, 32'(stale));
		chk("late read", 32'h2a5, 32'(fresh));
		rchk(ACIF_OFS_RESULT, 32'h2a5, "polled result");
		wrt(ACIF_OFS_CTRL, 32'h13);
		clear_all();
	endtask
	// In early mode the flag follows the latch, so even the quickest transfer sees the new result.
	task automatic t_early();
		wrt(ACIF_OFS_LOST_CNT, 32'h0);
		wrt(ACIF_OFS_FORCE, 32'h2);
		rchk(ACIF_OFS_FLAG, 32'h2, "forced flag");
		wrt(ACIF_OFS_CTRL, 32'h03);
		conv(12'h3c3);
		chk("early mode read", 32'h3c3, 32'(stale));
		rchk(ACIF_OFS_FLAG, 32'hf, "flags early mode");
		rchk(ACIF_OFS_LOST_CNT, 32'h1, "lost count");
		rchk(ACIF_OFS_IRQ_STAT, 32'h2f, "irq status lost");
		wrt(ACIF_OFS_CTRL, 32'h13);
		clear_all();
	endtask
	task automatic t_irq();
		conv(12'h055);
		chk("irq masked", 32'h0, 32'(irq));
		rchk(ACIF_OFS_IRQ_STAT, 32'hf, "irq status");
		wrt(ACIF_OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge mclk);
		chk("irq unmasked", 32'h1, 32'(irq));
		wrt(ACIF_OFS_IRQ_STAT, 32'h1);
		clk_en <= 1'b0;
		@(negedge mclk);
		chk("stalled ready", 32'h0, 32'(pready));
		@(posedge mclk);
		clk_en <= 1'b1;
		repeat (2) @(posedge mclk);
		chk("irq cleared", 32'h0, 32'(irq));
	endtask
	task automatic summarize();
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		conv_done = 1'b0;
		conv_data = '0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		t_reset();
		t_block();
		t_cont();
		t_collide();
		t_dma();
		t_early();
		t_irq();
		summarize();
	end
	// A hang is cut off well beyond the few hundred cycles the scenarios need.
	initial begin
		repeat (4000) @(posedge mclk);
		fails++;
		summarize();
	end
endmodule
bind acif_top acif_checker chk_u (.MCLK, .RST_B, .CLK_EN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY,
	.PSLVERR, .CONV_DONE, .CONV_DATA, .CONVERSION_RESULT, .CONV_IRQ_FLAG, .TRIG_DMA, .TRIG_CPU);
